// [hw/ghp_map.svh]
// constants of the graphics host bus and transfer port
// assumes inclusion by every design file of the port
`ifndef GHP_MAP_SVH
`define GHP_MAP_SVH

`define GHP_ADDR_W 22
`define GHP_DATA_W 16
`define GHP_MODE_X1 3'h0
`define GHP_MODE_X2 3'h1
`define GHP_MODE_X4 3'h2
`define GHP_MULT_X1 2'h0
`define GHP_MULT_X2 2'h1
`define GHP_MULT_X4 2'h2
`define GHP_MULT_BAD 2'h3
`define GHP_XMODE_MEM 2'h1
`define GHP_XMODE_IMG 2'h3
`define GHP_AMODE_SINGLE_A 2'h0
`define GHP_AMODE_SINGLE_B 2'h1
`define GHP_AMODE_DUAL 2'h2
`define GHP_BE_WORD 2'h3
`define GHP_WAIT_MAX_CYC 3
`define GHP_WAIT_MIN_CYC 1

`endif

// [hw/ghp_pkg.sv]
// types shared by the graphics host bus and transfer port
// assumes the constant header ghp_map.svh
`include "ghp_map.svh"
`default_nettype none
package ghp_pkg;
    typedef enum logic [2:0] {
        GHP_IDLE = 3'h1,
        GHP_BUSY = 3'h2,
        GHP_DONE = 3'h4
    } ghp_state_type;

    typedef struct packed {
        logic is_reg;
        logic write;
        logic [1:0] byte_en;
        logic [`GHP_ADDR_W-1:0] addr;
        logic [`GHP_DATA_W-1:0] wdata;
    } ghp_req_type;

    typedef struct packed {
        logic [1:0] xfer_mode;
        logic [1:0] addr_mode;
        logic [`GHP_ADDR_W-1:0] start_addr;
        logic [`GHP_ADDR_W-1:0] word_count;
    } ghp_xfer_cfg_type;
endpackage : ghp_pkg
`default_nettype wire

// [hw/ghp_dma_counter.sv]
// on-chip address and word counter for transfer cycles
// assumes load and step are never high together
`include "ghp_map.svh"
`default_nettype none
module ghp_dma_counter (
    input wire logic clk,
    input wire logic srst,
    input wire logic load,
    input wire logic step,
    input wire logic [`GHP_ADDR_W-1:0] start_addr,
    input wire logic [`GHP_ADDR_W-1:0] word_count,
    output logic [`GHP_ADDR_W-1:0] addr,
    output logic last
);
    logic [`GHP_ADDR_W-1:0] addr_q, addr_d, left_q, left_d;

    always_comb begin
        addr_d = addr_q;
        left_d = left_q;
        if (load) begin
            addr_d = start_addr;
            left_d = word_count;
        end else if (step) begin
            addr_d = addr_q + `GHP_ADDR_W'(1);
            left_d = left_q - `GHP_ADDR_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            addr_q <= '0;
            left_q <= '0;
        end else begin
            addr_q <= addr_d;
            left_q <= left_d;
        end
    end

    assign addr = addr_q;
    assign last = (left_q == `GHP_ADDR_W'(1));
endmodule : ghp_dma_counter
`default_nettype wire

// [hw/ghp_host_port.sv]
// host bus and cycle-stealing transfer port of the graphics controller
// assumes host pins synchronous to CLK_SYS; internal side answers via ready/valid
`include "ghp_map.svh"
`default_nettype none
// Behaviour
// - mode pins captured once after reset
// - mode pins pick x1, x2, x4 multiplier
// - reset returns pins and state to initial
// - memory select or register select decodes target
// - byte address; registers word only
// - write strobes choose low, high or word
// - wait asserted within three cycles of access
// - wait lasts at least one operating cycle
// - reads are whole words on read strobe
// - request raised when transfer set up
// - address mode picks single or dual timing
// - dual mode selected by acknowledge, select ignored
// - counter supplies addresses and counts words
module ghp_host_port (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic CLK_MULT_SEL_BIT2,
    input wire logic CLK_MULT_SEL_BIT1,
    input wire logic CLK_MULT_SEL_BIT0,
    output logic [1:0] CLK_MULT,
    output logic MODE_PROHIBITED,
    input wire logic MEMORY_SELECT_N,
    input wire logic REGISTER_SELECT_N,
    input wire logic READ_STROBE_N,
    input wire logic WRITE_STROBE_LOW_BYTE_N,
    input wire logic WRITE_STROBE_HIGH_BYTE_N,
    input wire logic [`GHP_ADDR_W-1:0] ADDR,
    input wire logic [`GHP_DATA_W-1:0] DATA_IN,
    output logic [`GHP_DATA_W-1:0] DATA_OUT,
    output logic DATA_OE,
    output logic WAIT_N,
    output logic TRANSFER_REQUEST_N,
    input wire logic TRANSFER_ACK_N,
    input wire ghp_pkg::ghp_xfer_cfg_type XFER_CFG,
    input wire logic XFER_START,
    output logic XFER_ACTIVE,
    output logic XFER_FINISHED_FLAG,
    output logic ACCESS_ERROR,
    output logic INT_REQ_VALID,
    output ghp_pkg::ghp_req_type INT_REQ,
    input wire logic INT_REQ_READY,
    input wire logic INT_RD_VALID,
    input wire logic [`GHP_DATA_W-1:0] INT_RD_DATA
);
    import ghp_pkg::*;

    function automatic logic [1:0] mult_decode(input logic [2:0] pins);
        unique case (pins)
            `GHP_MODE_X1: mult_decode = `GHP_MULT_X1;
            `GHP_MODE_X2: mult_decode = `GHP_MULT_X2;
            `GHP_MODE_X4: mult_decode = `GHP_MULT_X4;
            default: mult_decode = `GHP_MULT_BAD;
        endcase
    endfunction : mult_decode

    // mode strap capture
    logic [2:0] mode_pins;
    logic mode_taken_q, mode_taken_d;
    logic [1:0] mult_q, mult_d;

    assign mode_pins = {CLK_MULT_SEL_BIT2, CLK_MULT_SEL_BIT1, CLK_MULT_SEL_BIT0};

    always_comb begin
        mode_taken_d = 1'b1;
        mult_d = mult_q;
        if (!mode_taken_q) begin
            mult_d = mult_decode(mode_pins);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            mode_taken_q <= 1'b0;
            mult_q <= `GHP_MULT_X1;
        end else begin
            mode_taken_q <= mode_taken_d;
            mult_q <= mult_d;
        end
    end

    assign CLK_MULT = mult_q;
    assign MODE_PROHIBITED = mode_taken_q && (mult_q == `GHP_MULT_BAD);

    // access decode
    logic strobe_any, wr_any, cpu_sel, dma_sel, dual_q, cfg_ok;
    ghp_state_type state_q, state_d;
    ghp_req_type req_q, req_d;
    logic drop_q, drop_d, from_dma_q, from_dma_d, wait_n_q, wait_n_d;
    logic [`GHP_DATA_W-1:0] rdata_q, rdata_d;
    logic active_q, active_d, fin_q, fin_d, err_q, err_d, dual_d;
    logic [1:0] xmode_q, xmode_d;
    logic done, load, step, last;
    logic [`GHP_ADDR_W-1:0] cnt_addr;

    assign wr_any = !WRITE_STROBE_LOW_BYTE_N || !WRITE_STROBE_HIGH_BYTE_N;
    assign strobe_any = !READ_STROBE_N || wr_any;
    assign cpu_sel = (!MEMORY_SELECT_N ^ !REGISTER_SELECT_N) && TRANSFER_ACK_N;
    // acknowledge with the strobe of the mode selects; memory select is not looked at
    assign dma_sel = active_q && !TRANSFER_ACK_N
        && (dual_q ? wr_any : !READ_STROBE_N);
    assign cfg_ok = (XFER_CFG.xfer_mode == `GHP_XMODE_MEM || XFER_CFG.xfer_mode == `GHP_XMODE_IMG)
        && (XFER_CFG.addr_mode != 2'h3) && (XFER_CFG.word_count != '0);
    assign load = XFER_START && !active_q && cfg_ok;
    assign done = drop_q || (req_q.write ? INT_REQ_READY : INT_RD_VALID);
    assign step = (state_q == GHP_BUSY) && done && from_dma_q;

    always_comb begin
        state_d = state_q;
        req_d = req_q;
        drop_d = drop_q;
        from_dma_d = from_dma_q;
        wait_n_d = wait_n_q;
        rdata_d = rdata_q;
        err_d = 1'b0;
        unique case (state_q)
            GHP_IDLE: begin
                if (dma_sel) begin
                    req_d.is_reg = (xmode_q == `GHP_XMODE_IMG);
                    req_d.write = 1'b1;
                    req_d.byte_en = `GHP_BE_WORD;
                    req_d.addr = cnt_addr;
                    req_d.wdata = DATA_IN;
                    drop_d = 1'b0;
                    from_dma_d = 1'b1;
                    wait_n_d = 1'b0;
                    state_d = GHP_BUSY;
                end else if (cpu_sel && strobe_any) begin
                    req_d.is_reg = !REGISTER_SELECT_N;
                    req_d.write = READ_STROBE_N;
                    req_d.byte_en = READ_STROBE_N
                        ? {!WRITE_STROBE_HIGH_BYTE_N, !WRITE_STROBE_LOW_BYTE_N}
                        : `GHP_BE_WORD;
                    req_d.addr = ADDR;
                    req_d.wdata = DATA_IN;
                    // byte write to a register is dropped
                    drop_d = !REGISTER_SELECT_N && READ_STROBE_N
                        && !(!WRITE_STROBE_HIGH_BYTE_N && !WRITE_STROBE_LOW_BYTE_N);
                    err_d = drop_d;
                    from_dma_d = 1'b0;
                    wait_n_d = 1'b0;
                    state_d = GHP_BUSY;
                end
            end
            GHP_BUSY: begin
                if (done) begin
                    wait_n_d = 1'b1;
                    if (!req_q.write) begin
                        rdata_d = INT_RD_DATA;
                    end
                    state_d = GHP_DONE;
                end
            end
            GHP_DONE: begin
                if (!strobe_any) begin
                    state_d = GHP_IDLE;
                end
            end
            default: begin
                state_d = GHP_IDLE;
                wait_n_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            state_q <= GHP_IDLE;
            req_q <= '0;
            drop_q <= 1'b0;
            from_dma_q <= 1'b0;
            wait_n_q <= 1'b1;
            rdata_q <= '0;
            err_q <= 1'b0;
        end else begin
            state_q <= state_d;
            req_q <= req_d;
            drop_q <= drop_d;
            from_dma_q <= from_dma_d;
            wait_n_q <= wait_n_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // transfer control
    always_comb begin
        active_d = active_q;
        fin_d = fin_q;
        dual_d = dual_q;
        xmode_d = xmode_q;
        if (load) begin
            active_d = 1'b1;
            fin_d = 1'b0;
            dual_d = (XFER_CFG.addr_mode == `GHP_AMODE_DUAL);
            xmode_d = XFER_CFG.xfer_mode;
        end else if (step && last) begin
            active_d = 1'b0;
            fin_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            active_q <= 1'b0;
            fin_q <= 1'b0;
            dual_q <= 1'b0;
            xmode_q <= `GHP_XMODE_MEM;
        end else begin
            active_q <= active_d;
            fin_q <= fin_d;
            dual_q <= dual_d;
            xmode_q <= xmode_d;
        end
    end

    ghp_dma_counter u_counter (
        .clk(CLK_SYS),
        .srst(SRST),
        .load(load),
        .step(step),
        .start_addr(XFER_CFG.start_addr),
        .word_count(XFER_CFG.word_count),
        .addr(cnt_addr),
        .last(last)
    );

    // request falls anew for every word
    assign TRANSFER_REQUEST_N = !(active_q && state_q == GHP_IDLE);
    assign XFER_ACTIVE = active_q;
    assign XFER_FINISHED_FLAG = fin_q;
    assign ACCESS_ERROR = err_q;
    assign WAIT_N = wait_n_q;
    assign DATA_OUT = rdata_q;
    assign DATA_OE = (state_q == GHP_DONE) && !req_q.write && !READ_STROBE_N;
    assign INT_REQ_VALID = (state_q == GHP_BUSY) && !drop_q;
    assign INT_REQ = req_q;

    // checks
    property p_mode_hold;
        @(posedge CLK_SYS) disable iff (SRST)
        mode_taken_q && $past(mode_taken_q) |-> $stable(CLK_MULT);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed after capture");

    property p_mode_decode;
        @(posedge CLK_SYS) disable iff (SRST)
        $rose(mode_taken_q) |-> CLK_MULT == mult_decode($past(mode_pins));
    endproperty
    a_mode_decode: assert property (p_mode_decode) else $error("bad multiplier code");

    property p_reset_state;
        @(posedge CLK_SYS) SRST |=> WAIT_N && TRANSFER_REQUEST_N && !XFER_FINISHED_FLAG;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("outputs not initial");

    property p_decode;
        @(posedge CLK_SYS) disable iff (SRST)
        state_q == GHP_IDLE && !dma_sel && cpu_sel && strobe_any
        |=> state_q == GHP_BUSY && INT_REQ.is_reg == !$past(REGISTER_SELECT_N);
    endproperty
    a_decode: assert property (p_decode) else $error("wrong access target");

    property p_byte_lanes;
        @(posedge CLK_SYS) disable iff (SRST)
        state_q == GHP_IDLE && !dma_sel && cpu_sel && READ_STROBE_N && wr_any
        |=> INT_REQ.byte_en
            == {!$past(WRITE_STROBE_HIGH_BYTE_N), !$past(WRITE_STROBE_LOW_BYTE_N)};
    endproperty
    a_byte_lanes: assert property (p_byte_lanes) else $error("byte lanes wrong");

    property p_wait_soon;
        @(posedge CLK_SYS) disable iff (SRST)
        state_q == GHP_IDLE && (dma_sel || (cpu_sel && strobe_any)) |-> ##[1:3] !WAIT_N;
    endproperty
    a_wait_soon: assert property (p_wait_soon) else $error("wait late");

    property p_wait_min;
        @(posedge CLK_SYS) disable iff (SRST)
        $fell(WAIT_N) |-> state_q == GHP_BUSY;
    endproperty
    a_wait_min: assert property (p_wait_min) else $error("wait too short");

    property p_wait_hold;
        @(posedge CLK_SYS) disable iff (SRST)
        INT_REQ_VALID && !(INT_REQ.write ? INT_REQ_READY : INT_RD_VALID) |=> !WAIT_N;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait released early");

    property p_read_word;
        @(posedge CLK_SYS) disable iff (SRST)
        INT_REQ_VALID && !INT_REQ.write |-> INT_REQ.byte_en == `GHP_BE_WORD;
    endproperty
    a_read_word: assert property (p_read_word) else $error("partial read");

    property p_request;
        @(posedge CLK_SYS) disable iff (SRST)
        // a host access in flight delays the request legally
        load && state_q == GHP_IDLE && !strobe_any |=> !TRANSFER_REQUEST_N;
    endproperty
    a_request: assert property (p_request) else $error("no transfer request");

    property p_dma_addr;
        @(posedge CLK_SYS) disable iff (SRST)
        state_q == GHP_IDLE && dma_sel |=> INT_REQ.addr == $past(cnt_addr) && from_dma_q;
    endproperty
    a_dma_addr: assert property (p_dma_addr) else $error("bus address used");

    property p_finish;
        @(posedge CLK_SYS) disable iff (SRST)
        step && last |=> XFER_FINISHED_FLAG && !XFER_ACTIVE && TRANSFER_REQUEST_N;
    endproperty
    a_finish: assert property (p_finish) else $error("finish not flagged");

    c_cpu_read: cover property (@(posedge CLK_SYS) disable iff (SRST)
        INT_REQ_VALID && !INT_REQ.write ##1 DATA_OE);
    c_dual_word: cover property (@(posedge CLK_SYS) disable iff (SRST) dual_q && step);
    c_finish: cover property (@(posedge CLK_SYS) disable iff (SRST) $rose(XFER_FINISHED_FLAG));
endmodule : ghp_host_port
`default_nettype wire

// [testbench/ghp_host_model.sv]
// host cpu bus and transfer controller model driving the graphics host port
// assumes the port samples every pin on the rising edge of clk
`default_nettype none
module ghp_host_model (
    input wire logic clk,
    input wire logic wait_n,
    input wire logic req_n,
    input wire logic [15:0] rdata,
    output logic mem_sel_n,
    output logic reg_sel_n,
    output logic rd_n,
    output logic wlo_n,
    output logic whi_n,
    output logic ack_n,
    output logic [21:0] addr,
    output logic [15:0] wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {mem_sel_n, reg_sel_n, rd_n, wlo_n, whi_n, ack_n} = 6'h3f;
        addr = 22'h0;
        wdata = 16'h0;
    end
    // pins = {mem, reg, rd, wlo, whi, ack}; entered just after a rising edge
    task automatic cycle(input logic [5:0] pins, input logic [21:0] a, input logic [15:0] d,
                         output logic [15:0] q, output int lat, output int wid);
        lat = 0;
        wid = 0;
        while (!pins[0] && req_n && lat < 50) begin
            @(posedge clk);
            #1 lat++;
        end
        lat = 0;
        {mem_sel_n, reg_sel_n, rd_n, wlo_n, whi_n, ack_n} = pins;
        addr = a & 22'h0fffff;
        wdata = d;
        do begin
            @(posedge clk);
            #1 lat++;
        end while (wait_n && lat < 20);
        while (!wait_n && wid < 40) begin
            @(posedge clk);
            #1 wid++;
        end
        // hold the cycle up to the edge that samples wait released
        @(posedge clk);
        q = rdata;
        #1 {mem_sel_n, reg_sel_n, rd_n, wlo_n, whi_n, ack_n} = 6'h3f;
        // released lines must not keep their last value
        addr = ~addr;
        wdata = ~wdata;
        repeat (2) @(posedge clk);
        #1;
    endtask : cycle
endmodule : ghp_host_model
`default_nettype wire

// [testbench/ghp_host_port_tb.sv]
// self-checking bench of the graphics host bus and transfer port
// assumes the design files and the host model compile first
`include "ghp_map.svh"
`default_nettype none
module ghp_host_port_tb;
    import ghp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, srst = 1, go = 0, xstart = 0;
    logic [2:0] strap = 3'h0;
    logic [15:0] rd_word = 16'h0;
    ghp_xfer_cfg_type cfg = '0;
    ghp_req_type ireq;
    wire logic [1:0] mult;
    wire logic [21:0] addr;
    wire logic [15:0] din, dout;
    wire logic prohib, msel_n, rsel_n, rd_n, wlo_n, whi_n, oe, wait_n, req_n, ack_n;
    wire logic xactive, xdone, acc_err, iv;
    wire logic ir = iv & go & ireq.write;
    wire logic ird = iv & go & !ireq.write;
    ghp_req_type got[$];
    int error_cnt = 0, num_checks = 0, err_seen = 0, oe_cnt = 0;
    // 50 MHz operating clock, 20 ns period
    always #10 clk = ~clk;
    // internal side answers after a random number of cycles
    always @(posedge clk) go <= #1 ($urandom % 3) != 0;
    always @(posedge clk) begin
        if ((ir | ird) === 1'b1) got.push_back(ireq);
        if (acc_err === 1'b1) err_seen++;
        if (oe === 1'b1) oe_cnt++;
    end
    ghp_host_port ghp_host_port_i (.CLK_SYS(clk), .SRST(srst), .CLK_MULT_SEL_BIT2(strap[2]),
        .CLK_MULT_SEL_BIT1(strap[1]), .CLK_MULT_SEL_BIT0(strap[0]), .CLK_MULT(mult),
        .MODE_PROHIBITED(prohib), .MEMORY_SELECT_N(msel_n), .REGISTER_SELECT_N(rsel_n),
        .READ_STROBE_N(rd_n), .WRITE_STROBE_LOW_BYTE_N(wlo_n), .WRITE_STROBE_HIGH_BYTE_N(whi_n),
        .ADDR(addr), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe), .WAIT_N(wait_n),
        .TRANSFER_REQUEST_N(req_n), .TRANSFER_ACK_N(ack_n), .XFER_CFG(cfg),
        .XFER_START(xstart), .XFER_ACTIVE(xactive), .XFER_FINISHED_FLAG(xdone),
        .ACCESS_ERROR(acc_err), .INT_REQ_VALID(iv), .INT_REQ(ireq), .INT_REQ_READY(ir),
        .INT_RD_VALID(ird), .INT_RD_DATA(rd_word));
    ghp_host_model ghp_host_model_i (.clk(clk), .wait_n(wait_n), .req_n(req_n), .rdata(dout),
        .mem_sel_n(msel_n), .reg_sel_n(rsel_n), .rd_n(rd_n), .wlo_n(wlo_n), .whi_n(whi_n),
        .ack_n(ack_n), .addr(addr), .wdata(din));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    function automatic logic [2:0] exp_mode(input logic [2:0] p);
        return (p > 3'h2) ? 3'h7 : {1'b0, p[1:0]};
    endfunction : exp_mode
    task automatic do_reset(input logic [2:0] p);
        srst = 1;
        strap = p;
        repeat (12) @(posedge clk);
        #1 check({wait_n, req_n, oe, xactive, xdone, acc_err, mult}, 8'hc0);
        srst = 0;
        @(posedge clk);
        #1 strap = ~p;
    endtask : do_reset
    task automatic host(input logic [5:0] pins, input logic [21:0] a, input logic [15:0] d,
                        output logic [15:0] q);
        int lat, wid;
        ghp_host_model_i.cycle(pins, a, d, q, lat, wid);
        check(lat <= 3, 1);
        check(wid >= 1 && wid < 40, 1);
    endtask : host
    task automatic expect_req(input logic [41:0] e, input bit with_data);
        ghp_req_type r;
        check(got.size(), 1);
        r = got.size() ? got.pop_front() : '0;
        check(r[41:16], e[41:16]);
        if (with_data) check(r[15:0], e[15:0]);
        got.delete();
    endtask : expect_req
    initial begin
        logic [15:0] q, d;
        logic [21:0] a;
        logic [1:0] be;
        logic [3:0] tbl [4];
        int n;
        void'($urandom(89));
        for (int p = 0; p < 8; p++) begin
            do_reset(p[2:0]);
            repeat (2) @(posedge clk);
            #1 check({prohib, mult}, exp_mode(p[2:0]));
        end
        do_reset(`GHP_MODE_X4);
        for (int i = 0; i < 12; i++) begin
            be = (i < 3) ? 2'(i + 1) : 2'(1 + $urandom % 3);
            a = 22'($urandom);
            d = 16'($urandom);
            host({3'b011, ~be[0], ~be[1], 1'b1}, a, d, q);
            expect_req({2'b01, be, a & 22'h0fffff, d}, 1);
        end
        check(oe_cnt, 0);
        for (int i = 0; i < 4; i++) begin
            rd_word = 16'($urandom);
            a = 22'($urandom);
            oe_cnt = 0;
            host({i[0], ~i[0], 4'b0111}, a, 16'h0, q);
            check(q, rd_word);
            check(oe_cnt != 0, 1);
            expect_req({i[0], 3'b011, a & 22'h0fffff, 16'h0}, 0);
        end
        a = 22'($urandom);
        d = 16'($urandom);
        host(6'b101001, a, d, q);
        expect_req({4'b1111, a & 22'h0fffff, d}, 1);
        err_seen = 0;
        host(6'b101011, a, d, q);
        check({got.size(), err_seen}, {32'h0, 32'h1});
        // {xfer_mode, addr_mode}: refused entry last
        tbl = '{{`GHP_XMODE_MEM, `GHP_AMODE_SINGLE_A}, {`GHP_XMODE_IMG, `GHP_AMODE_SINGLE_B},
                {`GHP_XMODE_MEM, `GHP_AMODE_DUAL}, {`GHP_XMODE_IMG, 2'h3}};
        foreach (tbl[t]) begin
            n = (t == 3) ? 0 : 1 + $urandom % 3;
            cfg = {tbl[t][3:2], tbl[t][1:0], 22'($urandom), 22'(n ? n : 1)};
            xstart = 1;
            @(posedge clk);
            #1 xstart = 0;
            check({req_n, xactive, xdone}, {n == 0, n != 0, n == 0});
            for (int k = 0; k < n; k++) begin
                d = 16'($urandom);
                // dual: ack with write strobes, memory select low but ignored
                host(t == 2 ? 6'b011000 : 6'b110110, 22'($urandom), d, q);
                expect_req({t == 1, 3'b111, 22'(cfg.start_addr + k), d}, 1);
            end
            repeat (3) @(posedge clk);
            #1 check({req_n, xactive, xdone}, 3'b101);
        end
        tally_and_finish();
    end
    initial begin
        #400us;
        error_cnt++;
        tally_and_finish();
    end
endmodule : ghp_host_port_tb
`default_nettype wire
